//--- dv/tb.sv
// Purpose: Self-checking bench for the receiver.
// Assumes: Default parameters, divisor 7 in the async and sync tests.
// Notes:   Ends through wrap_up only.
`timescale 1ns/10ps
`default_nettype none
`include "usrx_map.svh"
module tb;
   localparam int BIT_NS = 8 * 16 * 10;
   logic       core_clk_i;
   logic       srst_i;
   logic [7:0] bus_addr_i;
   logic [7:0] bus_wdata_i;
   logic       bus_wr_i;
   logic       bus_rd_i;
   logic [7:0] bus_rdata_o;
   logic       ser_data;
   logic       serial_clk_o;
   logic       serial_clk_oe_o;
   logic       rcv_irq_o;
   int         errors;
   int         total_checks;
   int         cyc;
   logic [7:0] d;
   usrx_top dut (.core_clk_i(core_clk_i), .srst_i(srst_i),
      .bus_addr_i(bus_addr_i), .bus_wdata_i(bus_wdata_i),
      .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i), .bus_rdata_o(bus_rdata_o),
      .serial_data_in_pin_i(ser_data), .serial_clk_o(serial_clk_o),
      .serial_clk_oe_o(serial_clk_oe_o), .rcv_irq_o(rcv_irq_o));
   usrx_serial_partner peer (.serial_clk_i(serial_clk_o),
      .serial_data_o(ser_data));
   // ------------------------------------------------------------
   // Bus and check tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [9:0] got, input logic [9:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [5:0] idx, input logic [7:0] v);
      @(posedge core_clk_i);
      bus_wr_i    <= 1'b1;
      bus_addr_i  <= {idx, 2'b00};
      bus_wdata_i <= v;
      @(posedge core_clk_i);
      bus_wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [5:0] idx, output logic [7:0] v);
      @(posedge core_clk_i);
      bus_rd_i   <= 1'b1;
      bus_addr_i <= {idx, 2'b00};
      @(posedge core_clk_i);
      bus_rd_i <= 1'b0;
      #1 v = bus_rdata_o;
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge core_clk_i);
      #1;
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset;
      rd(`USRX_IDX_RCV_STAT, d);
      chk(d, 8'h00);
      rd(`USRX_IDX_BAUD, d);
      chk(d, 8'h00);
      rd(`USRX_IDX_IRQ_EN, d);
      chk(d, 8'h00);
      wr(`USRX_IDX_FLAGS, 8'hFF);
      rd(`USRX_IDX_FLAGS, d);
      chk(d, 8'h00);
      rd(6'h19, d);
      chk(d, 8'h00);
      $display("test reset done");
   endtask
   task automatic t_async;
      wr(`USRX_IDX_BAUD, 8'h07);
      wr(`USRX_IDX_IRQ_EN, 8'h01);
      wr(`USRX_IDX_RCV_STAT, 8'hD0);
      idle(20);
      peer.send_async(10'h1A5, 9, 1'b1, BIT_NS);
      peer.send_async(10'h03C, 9, 1'b0, BIT_NS);
      peer.send_async(10'h2FF, 9, 1'b1, BIT_NS);
      idle(300);
      chk(rcv_irq_o, 1'b1);
      wr(`USRX_IDX_IRQ_EN, 8'h00);
      #1 chk(rcv_irq_o, 1'b0);
      rd(`USRX_IDX_FLAGS, d);
      chk(d, 8'h01);
      wr(`USRX_IDX_IRQ_EN, 8'h01);
      rd(`USRX_IDX_RCV_STAT, d);
      chk(d, 8'hD3);
      rd(`USRX_IDX_RCV_BUF, d);
      chk(d, 8'hA5);
      rd(`USRX_IDX_RCV_STAT, d);
      chk(d, 8'hD6);
      rd(`USRX_IDX_RCV_BUF, d);
      chk(d, 8'h3C);
      rd(`USRX_IDX_FLAGS, d);
      chk(d, 8'h00);
      peer.send_async(10'h155, 9, 1'b1, BIT_NS);
      idle(300);
      rd(`USRX_IDX_FLAGS, d);
      chk(d, 8'h00);
      wr(`USRX_IDX_RCV_STAT, 8'hC0);
      rd(`USRX_IDX_RCV_STAT, d);
      chk(d, 8'hC0);
      $display("test async done");
   endtask
   task automatic t_sync;
      logic got;
      got = 1'b0;
      peer.load_sync(10'h35A);
      wr(`USRX_IDX_TX_STAT, 8'h90);
      wr(`USRX_IDX_RCV_STAT, 8'hA0);
      for (int i = 0; i < 100 && !got; i++) begin
         rd(`USRX_IDX_FLAGS, d);
         got = d[0];
      end
      chk(got, 1'b1);
      rd(`USRX_IDX_RCV_STAT, d);
      chk(d, 8'h80);
      rd(`USRX_IDX_RCV_BUF, d);
      chk(d, 8'h5A);
      idle(40);
      chk({serial_clk_oe_o, serial_clk_o}, 2'b10);
      // Both enables: continuous wins, so the third word overruns.
      // The wait puts the disable inside a low clock phase.
      wr(`USRX_IDX_RCV_STAT, 8'hB0);
      idle(464);
      rd(`USRX_IDX_RCV_STAT, d);
      chk(d, 8'hB2);
      wr(`USRX_IDX_RCV_STAT, 8'h80);
      rd(`USRX_IDX_RCV_STAT, d);
      chk(d, 8'h80);
      chk(rcv_irq_o, 1'b1);
      $display("test sync done");
   endtask
   // ------------------------------------------------------------
   // Clock, reset, sequence and timeout
   // ------------------------------------------------------------
   initial begin
      core_clk_i = 1'b0;
      forever #5 core_clk_i = ~core_clk_i;
   end
   always @(posedge core_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         errors++;
         wrap_up();
      end
   end
   initial begin
      {errors, total_checks, cyc} = '0;
      {srst_i, bus_wr_i, bus_rd_i} = 3'b100;
      {bus_addr_i, bus_wdata_i} = 16'h0000;
      repeat (16) @(posedge core_clk_i);
      srst_i <= 1'b0;
      t_reset();
      t_async();
      t_sync();
      wrap_up();
   end
endmodule
bind usrx_top usrx_properties #(.ADDR_W(ADDR_W), .DIV_W(DIV_W)) chk_i (
   .core_clk_i(core_clk_i), .srst_i(srst_i), .bus_addr_i(bus_addr_i),
   .bus_wdata_i(bus_wdata_i), .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i),
   .bus_rdata_o(bus_rdata_o), .serial_data_in_pin_i(serial_data_in_pin_i),
   .serial_clk_o(serial_clk_o), .serial_clk_oe_o(serial_clk_oe_o),
   .rcv_irq_o(rcv_irq_o));
`default_nettype wire

//--- dv/usrx_properties.sv
// Purpose: Port-level assertions for the receiver.
// Assumes: Register state is shadowed from bus writes only.
// Notes:   Bound to usrx_top from the bench top file.
`timescale 1ns/10ps
`default_nettype none
`include "usrx_map.svh"
module usrx_properties #(
   parameter int ADDR_W = 8,
   parameter int DIV_W  = 8
) (
   input wire logic              core_clk_i,
   input wire logic              srst_i,
   input wire logic [ADDR_W-1:0] bus_addr_i,
   input wire logic [7:0]        bus_wdata_i,
   input wire logic              bus_wr_i,
   input wire logic              bus_rd_i,
   input wire logic [7:0]        bus_rdata_o,
   input wire logic              serial_data_in_pin_i,
   input wire logic              serial_clk_o,
   input wire logic              serial_clk_oe_o,
   input wire logic              rcv_irq_o
);
   // ------------------------------------------------------------
   // Shadow registers
   // ------------------------------------------------------------
   localparam logic [7:0] A_STAT = {`USRX_IDX_RCV_STAT, 2'b00};
   localparam logic [7:0] A_BUF  = {`USRX_IDX_RCV_BUF, 2'b00};
   localparam logic [7:0] A_TX   = {`USRX_IDX_TX_STAT, 2'b00};
   localparam logic [7:0] A_BAUD = {`USRX_IDX_BAUD, 2'b00};
   localparam logic [7:0] A_IEN  = {`USRX_IDX_IRQ_EN, 2'b00};
   logic [7:0] baud_r;
   logic       ien_r;
   logic       port_r;
   logic       sync_r;
   logic       mast_r;
   logic [8:0] hi_cnt_r;
   wire  [7:0] addr8 = 8'(bus_addr_i);
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         {baud_r, ien_r, port_r, sync_r, mast_r} <= 12'h000;
         hi_cnt_r <= 9'h000;
      end else begin
         if (bus_wr_i && addr8 == A_BAUD) baud_r <= bus_wdata_i;
         if (bus_wr_i && addr8 == A_IEN) ien_r <= bus_wdata_i[0];
         if (bus_wr_i && addr8 == A_STAT) port_r <= bus_wdata_i[7];
         if (bus_wr_i && addr8 == A_TX) begin
            {mast_r, sync_r} <= {bus_wdata_i[7], bus_wdata_i[4]};
         end
         hi_cnt_r <= serial_clk_o ? hi_cnt_r + 9'h001 : 9'h000;
      end
   end
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (srst_i);
   sequence s_rd(a);
      bus_rd_i && addr8 == a;
   endsequence
   sequence s_flag_up;
      rcv_irq_o && ien_r && !(bus_rd_i && addr8 == A_BUF);
   endsequence
   a_rdata_idle: assert property (
      !$past(bus_rd_i) |-> bus_rdata_o == 8'h00)
      else $error("read data seen without a read");
   a_irq_gate: assert property (
      !ien_r |-> !rcv_irq_o)
      else $error("interrupt raised while disabled");
   a_flag_hold: assert property (
      s_flag_up |=> rcv_irq_o || !ien_r)
      else $error("receive flag cleared without a buffer read");
   a_ien_read: assert property (
      s_rd(A_IEN) |=> bus_rdata_o[0] == $past(ien_r))
      else $error("interrupt enable reads back wrong");
   a_baud_read: assert property (
      s_rd(A_BAUD) |=> bus_rdata_o == $past(baud_r))
      else $error("divisor reads back wrong");
   a_oe_mode: assert property (
      serial_clk_oe_o == (port_r && sync_r && mast_r))
      else $error("clock enable does not follow mode bits");
   a_clk_quiet: assert property (
      !serial_clk_oe_o && !$past(serial_clk_oe_o) |-> !serial_clk_o)
      else $error("serial clock moves outside master mode");
   a_clk_half: assert property (
      $fell(serial_clk_o) |-> hi_cnt_r == 9'(baud_r) + 9'h001)
      else $error("serial clock high phase has wrong length");
endmodule
`default_nettype wire

//--- dv/usrx_serial_partner.sv
// Purpose: Serial transmitter facing the receiver.
// Assumes: Line idles high; sync data changes on the rising clock.
// Notes:   Data changes at rising edges so it is settled at the fall.
`timescale 1ns/10ps
`default_nettype none
module usrx_serial_partner (
   input  wire logic serial_clk_i,
   output logic      serial_data_o
);
   logic [9:0] sync_word_r;
   initial begin
      serial_data_o = 1'b1;
      sync_word_r   = 10'h3FF;
   end
   // Start low, data LSB first, chosen stop level, then an idle bit.
   task automatic send_async(input logic [9:0] w, input int nbits,
                             input logic stop, input int bit_ns);
      serial_data_o = 1'b0;
      #(bit_ns);
      for (int i = 0; i < nbits; i++) begin
         serial_data_o = w[i];
         #(bit_ns);
      end
      serial_data_o = stop;
      #(bit_ns);
      serial_data_o = 1'b1;
      #(bit_ns);
   endtask
   task automatic load_sync(input logic [9:0] w);
      sync_word_r = w;
   endtask
   // After the word the line keeps changing so stale bits never pass.
   always @(posedge serial_clk_i) begin
      serial_data_o <= sync_word_r[0];
      sync_word_r   <= {~sync_word_r[0], sync_word_r[9:1]};
   end
endmodule
`default_nettype wire

//--- verilog/usrx_map.svh
// Purpose: Register indexes, field positions and reset values.
// Assumes: Byte address of a register is four times its index.
// Notes:   Definitions only.
`ifndef USRX_MAP_SVH
`define USRX_MAP_SVH

// ---------------------------------------------------------------
// Register indexes
// ---------------------------------------------------------------
`define USRX_IDX_RCV_STAT   6'h13
`define USRX_IDX_RCV_BUF    6'h14
`define USRX_IDX_TX_STAT    6'h15
`define USRX_IDX_FLAGS      6'h16
`define USRX_IDX_BAUD       6'h17
`define USRX_IDX_IRQ_EN     6'h18

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define USRX_B_PORT_EN      7
`define USRX_B_NINE_EN      6
`define USRX_B_SINGLE       5
`define USRX_B_CONT         4
`define USRX_B_FRAMING_ERROR         2
`define USRX_B_OVERRUN_ERROR         1
`define USRX_B_NINTH        0
`define USRX_B_CLK_MASTER   7
`define USRX_B_SYNC_MODE    4
`define USRX_B_RCV_FLAG     0
`define USRX_B_RCV_IRQ_EN   0

// ---------------------------------------------------------------
// Reset values and timing counts
// ---------------------------------------------------------------
`define USRX_RST_BYTE       8'h00
`define USRX_RST_BAUD       8'h00
`define USRX_OVS_LAST       4'hF
`define USRX_OVS_MID        4'h7
`define USRX_BITS_8         4'h8
`define USRX_BITS_9         4'h9

`endif

//--- verilog/usrx_pkg.sv
// Purpose: Types shared by the receiver.
// Assumes: Nothing beyond the map header.
// Notes:   States are one-hot.
`default_nettype none
package usrx_pkg;

   // ------------------------------------------------------------
   // Receiver states
   // ------------------------------------------------------------
   typedef enum logic [4:0] {
      ST_IDLE  = 5'h01,
      ST_START = 5'h02,
      ST_DATA  = 5'h04,
      ST_STOP  = 5'h08,
      ST_SYNC  = 5'h10
   } usrx_state_e;

   typedef logic [9:0] usrx_word_t;

endpackage
`default_nettype wire

//--- verilog/usrx_top.sv
// Purpose: Receive path of a USART, asynchronous and synchronous master.
// Assumes: Registers sit on a plain strobe port with 8-bit data.
// Notes:   The receive buffer is a two-entry FIFO of flip-flops.
`timescale 1ns/10ps
`default_nettype none
`include "usrx_map.svh"

// Behaviour
// [RULE1] Software loads divisor, selects async, enables port, then continuous.
// [RULE2] Software reads status before buffer to get ninth bit, framing.
// [RULE3] Both receive enables low, or port disabled, resets receive logic.
// [RULE4] Synchronous reception starts when single or continuous enable set.
// [RULE5] Synchronous master samples data on falling edge of own clock.
// [RULE6] Single receives one word; continuous runs on and has precedence.
// [RULE7] Last bit in moves shifter into FIFO when room exists.
// [RULE8] Receive flag set on transfer; interrupt only while enabled.
// [RULE9] Interrupt enable gates the request and never touches the flag.
// [RULE10] Receive flag read-only, clears when buffer read and FIFO empty.
// [RULE11] Buffer is two-deep FIFO; reads return stored words in order.
// [RULE12] Word completing with FIFO full sets overrun and is lost.
// [RULE13] Clearing continuous enable clears overrun; nothing else does.
// [RULE14] While overrun is set no word enters the FIFO.
// [RULE15] Ninth bit and framing error stored per word, shown for head.
// [RULE16] Buffer read advances ninth bit and framing status to next word.
// [RULE17] Software sets sync, port enable and clock master after divisor.
// [RULE18] Ninth-bit enable makes words nine bits long.
// [RULE19] Bit timing and master clock come from divisor-reloaded counter.
// [RULE20] Async detects start, shifts LSB first, low stop is framing error.
module usrx_top
   import usrx_pkg::*;
#(
   parameter int ADDR_W = 8,
   parameter int DIV_W  = 8
) (
   input  wire logic              core_clk_i,
   input  wire logic              srst_i,
   input  wire logic [ADDR_W-1:0] bus_addr_i,
   input  wire logic [7:0]        bus_wdata_i,
   input  wire logic              bus_wr_i,
   input  wire logic              bus_rd_i,
   output logic      [7:0]        bus_rdata_o,
   input  wire logic              serial_data_in_pin_i,
   output logic                   serial_clk_o,
   output logic                   serial_clk_oe_o,
   output logic                   rcv_irq_o
);

   // ------------------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------------------
   if (ADDR_W < 8) begin : g_chk_addr
      $error("ADDR_W must be at least 8");
   end
   if (DIV_W != 8) begin : g_chk_div
      $error("DIV_W must be 8 to match the divisor register");
   end

   // ------------------------------------------------------------
   // Functions
   // ------------------------------------------------------------
   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input logic [5:0]        idx);
      hit = (a[ADDR_W-1:2] == (ADDR_W-2)'(idx)) && (a[1:0] == 2'h0);
   endfunction

   // Shifter fills from the top, so an 8-bit word sits one place high.
   function automatic logic [8:0] align(input logic [8:0] sh,
                                        input logic       nine);
      align = nine ? sh : {1'b0, sh[8:1]};
   endfunction

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   logic              port_en_r;
   logic              nine_en_r;
   logic              single_r;
   logic              single_nxt;
   logic              cont_r;
   logic              overrun_error_r;
   logic              clk_master_r;
   logic              sync_mode_r;
   logic              irq_en_r;
   logic [DIV_W-1:0]  baud_r;
   logic [7:0]        rdata_r;
   logic [7:0]        rdata_nxt;

   logic              s1_r;
   logic              s2_r;
   logic              s3_r;
   logic              rx_r;

   usrx_state_e       state_r;
   usrx_state_e       state_nxt;
   logic [DIV_W-1:0]  baud_cnt_r;
   logic [3:0]        ovs_r;
   logic [3:0]        bit_cnt_r;
   logic [8:0]        shift_r;
   logic              sclk_r;

   usrx_word_t        fifo_r [2];
   logic              head_r;
   logic [1:0]        count_r;

   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   wire logic wr_stat  = bus_wr_i && hit(bus_addr_i, `USRX_IDX_RCV_STAT);
   wire logic wr_tx    = bus_wr_i && hit(bus_addr_i, `USRX_IDX_TX_STAT);
   wire logic wr_baud  = bus_wr_i && hit(bus_addr_i, `USRX_IDX_BAUD);
   wire logic wr_irq   = bus_wr_i && hit(bus_addr_i, `USRX_IDX_IRQ_EN);
   wire logic rd_stat  = bus_rd_i && hit(bus_addr_i, `USRX_IDX_RCV_STAT);
   wire logic rd_buf   = bus_rd_i && hit(bus_addr_i, `USRX_IDX_RCV_BUF);
   wire logic rd_tx    = bus_rd_i && hit(bus_addr_i, `USRX_IDX_TX_STAT);
   wire logic rd_flags = bus_rd_i && hit(bus_addr_i, `USRX_IDX_FLAGS);
   wire logic rd_baud  = bus_rd_i && hit(bus_addr_i, `USRX_IDX_BAUD);
   wire logic rd_irq   = bus_rd_i && hit(bus_addr_i, `USRX_IDX_IRQ_EN);

   // ------------------------------------------------------------
   // Receiver control terms
   // ------------------------------------------------------------
   wire logic       nine_bits = nine_en_r;                   // [RULE18]
   wire logic [3:0] last_bit  = nine_bits ? `USRX_BITS_9
                                          : `USRX_BITS_8;
   wire logic rx_off    = !port_en_r || (!single_r && !cont_r); // [RULE3]
   wire logic sync_run  = sync_mode_r && clk_master_r &&
                          (single_r || cont_r);               // [RULE4]
   wire logic async_run = !sync_mode_r && cont_r;
   wire logic tick      = (baud_cnt_r == '0);                 // [RULE19]
   wire logic ovs_end   = tick && (ovs_r == `USRX_OVS_LAST);
   wire logic ovs_mid   = tick && (ovs_r == `USRX_OVS_MID);
   wire logic sclk_fall = tick && sclk_r;                     // [RULE5]
   wire logic restart   = (state_r == ST_IDLE) && async_run && !rx_r;

   wire logic [3:0] bit_inc  = bit_cnt_r + 4'h1;
   wire logic       async_sh = (state_r == ST_DATA) && ovs_end;
   wire logic       sync_sh  = (state_r == ST_SYNC) && sclk_fall;
   wire logic       shift_en = async_sh || sync_sh;
   wire logic       word_end = shift_en && (bit_inc == last_bit);

   wire logic async_done = (state_r == ST_STOP) && ovs_end && !rx_off;
   wire logic sync_done  = sync_sh && (bit_inc == last_bit) && !rx_off;
   wire logic done       = async_done || sync_done;

   wire logic [8:0] word_bits = align(async_done ? shift_r
                                                 : {rx_r, shift_r[8:1]},
                                      nine_bits);
   wire logic       word_framing_error = async_done && !rx_r;           // [RULE20]
   wire usrx_word_t word_in   = {word_framing_error, word_bits};        // [RULE15]

   // ------------------------------------------------------------
   // FIFO control
   // ------------------------------------------------------------
   wire logic full     = (count_r == 2'h2);
   wire logic pop      = rd_buf && (count_r != 2'h0);          // [RULE11]
   wire logic push     = done && !overrun_error_r && !full;       // [RULE7] [RULE14]
   wire logic ovr_set  = done && !overrun_error_r && full;              // [RULE12]
   wire logic cont_clr = wr_stat && !bus_wdata_i[`USRX_B_CONT];
   wire logic wr_idx   = head_r ^ count_r[0];
   wire logic rcv_flag = (count_r != 2'h0);                    // [RULE10]
   // An empty FIFO shows zero status rather than unreset storage.
   wire usrx_word_t head_word = rcv_flag ? fifo_r[head_r] : '0; // [RULE16]

   // ------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------
   always_comb begin
      state_nxt = state_r;
      if (rx_off) begin
         state_nxt = ST_IDLE;                                  // [RULE3]
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (sync_run) begin
                  state_nxt = ST_SYNC;
               end else if (restart) begin
                  state_nxt = ST_START;
               end
            end
            ST_START: begin
               if (ovs_mid) begin
                  state_nxt = rx_r ? ST_IDLE : ST_DATA;        // [RULE20]
               end
            end
            ST_DATA: begin
               if (word_end) begin
                  state_nxt = ST_STOP;
               end
            end
            ST_STOP: begin
               if (ovs_end) begin
                  state_nxt = ST_IDLE;
               end
            end
            ST_SYNC: begin
               if (sync_done && !cont_r) begin
                  state_nxt = ST_IDLE;                         // [RULE6]
               end
            end
            default: begin
               state_nxt = ST_IDLE;
            end
         endcase
      end
   end

   // Single enable drops itself after one word unless continuous runs.
   always_comb begin
      single_nxt = single_r;
      if (wr_stat) begin
         single_nxt = bus_wdata_i[`USRX_B_SINGLE];
      end else if (sync_done && !cont_r) begin
         single_nxt = 1'b0;                                    // [RULE6]
      end
   end

   always_comb begin
      rdata_nxt = 8'h00;
      if (rd_stat) begin
         rdata_nxt[`USRX_B_PORT_EN] = port_en_r;
         rdata_nxt[`USRX_B_NINE_EN] = nine_en_r;
         rdata_nxt[`USRX_B_SINGLE]  = single_r;
         rdata_nxt[`USRX_B_CONT]    = cont_r;
         rdata_nxt[`USRX_B_FRAMING_ERROR]    = head_word[9];            // [RULE15]
         rdata_nxt[`USRX_B_OVERRUN_ERROR]    = overrun_error_r;
         rdata_nxt[`USRX_B_NINTH]   = head_word[8];
      end else if (rd_buf) begin
         rdata_nxt = head_word[7:0];
      end else if (rd_tx) begin
         rdata_nxt[`USRX_B_CLK_MASTER] = clk_master_r;
         rdata_nxt[`USRX_B_SYNC_MODE]  = sync_mode_r;
      end else if (rd_flags) begin
         rdata_nxt[`USRX_B_RCV_FLAG] = rcv_flag;               // [RULE10]
      end else if (rd_baud) begin
         rdata_nxt = baud_r;
      end else if (rd_irq) begin
         rdata_nxt[`USRX_B_RCV_IRQ_EN] = irq_en_r;
      end
   end

   // ------------------------------------------------------------
   // Pin synchroniser
   // ------------------------------------------------------------
   // A level counts only once the second and third stages agree.
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         s1_r <= 1'b1;
         s2_r <= 1'b1;
         s3_r <= 1'b1;
         rx_r <= 1'b1;
      end else begin
         s1_r <= serial_data_in_pin_i;
         s2_r <= s1_r;
         s3_r <= s2_r;
         rx_r <= (s2_r == s3_r) ? s3_r : rx_r;
      end
   end

   // ------------------------------------------------------------
   // Control registers
   // ------------------------------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         port_en_r    <= 1'b0;
         nine_en_r    <= 1'b0;
         single_r     <= 1'b0;
         cont_r       <= 1'b0;
         clk_master_r <= 1'b0;
         sync_mode_r  <= 1'b0;
         irq_en_r     <= 1'b0;
         baud_r       <= `USRX_RST_BAUD;
         rdata_r      <= `USRX_RST_BYTE;
      end else begin
         single_r <= single_nxt;
         rdata_r  <= rdata_nxt;
         if (wr_stat) begin
            port_en_r <= bus_wdata_i[`USRX_B_PORT_EN];
            nine_en_r <= bus_wdata_i[`USRX_B_NINE_EN];
            cont_r    <= bus_wdata_i[`USRX_B_CONT];
         end
         if (wr_tx) begin
            clk_master_r <= bus_wdata_i[`USRX_B_CLK_MASTER];
            sync_mode_r  <= bus_wdata_i[`USRX_B_SYNC_MODE];
         end
         if (wr_baud) begin
            baud_r <= bus_wdata_i;
         end
         if (wr_irq) begin
            irq_en_r <= bus_wdata_i[`USRX_B_RCV_IRQ_EN];       // [RULE9]
         end
      end
   end

   // Overrun: a new overrun in the clearing cycle still wins.
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         overrun_error_r <= 1'b0;
      end else if (ovr_set) begin
         overrun_error_r <= 1'b1;                                       // [RULE12]
      end else if (cont_clr) begin
         overrun_error_r <= 1'b0;                                       // [RULE13]
      end
   end

   // ------------------------------------------------------------
   // Bit timing and shifter
   // ------------------------------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         state_r    <= ST_IDLE;
         baud_cnt_r <= '0;
         ovs_r      <= 4'h0;
         bit_cnt_r  <= 4'h0;
         shift_r    <= 9'h000;
         sclk_r     <= 1'b0;
      end else begin
         state_r <= state_nxt;
         if (rx_off || restart || (state_r == ST_IDLE)) begin
            baud_cnt_r <= baud_r;                              // [RULE19]
            ovs_r      <= 4'h0;
            bit_cnt_r  <= 4'h0;
            sclk_r     <= 1'b0;
         end else begin
            baud_cnt_r <= tick ? baud_r : baud_cnt_r - 1'b1;
            if (tick) begin
               ovs_r <= ovs_mid && (state_r == ST_START) ? 4'h0
                                                         : ovs_r + 4'h1;
            end
            if (state_r == ST_SYNC && tick) begin
               sclk_r <= !sclk_r;                              // [RULE19]
            end
            if (shift_en) begin
               shift_r   <= {rx_r, shift_r[8:1]};  // [RULE20] [RULE5]
               bit_cnt_r <= word_end ? 4'h0 : bit_inc;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Receive FIFO
   // ------------------------------------------------------------
   // No reset on the storage: entries are only read once counted.
   always_ff @(posedge core_clk_i) begin
      if (push) begin
         fifo_r[wr_idx] <= word_in;                            // [RULE11]
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         head_r  <= 1'b0;
         count_r <= 2'h0;
      end else begin
         if (pop) begin
            head_r <= !head_r;                                 // [RULE16]
         end
         count_r <= count_r + {1'b0, push} - {1'b0, pop};      // [RULE8]
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign bus_rdata_o     = rdata_r;
   assign serial_clk_o    = sclk_r;
   assign serial_clk_oe_o = port_en_r && sync_mode_r && clk_master_r;
   assign rcv_irq_o       = rcv_flag && irq_en_r;        // [RULE8] [RULE9]

endmodule
`default_nettype wire
